// >>> hw/rtx_cfg_bank.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rtx_cfg_bank (
  input wire logic clk, // 20 MHz system clock
  input wire logic reset, // Synchronous, active high
  input wire logic clk_en, // Freezes all state when low
  input wire logic [7:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr_stb, // Write strobe
  input wire logic rd_stb, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after strobe
  input wire logic internal_envelope, // Internal transmit envelope
  input wire logic external_serial_input, // Pin, synchronised here
  input wire logic [15:0] user_crc16, // Stored user preset
  input wire logic [7:0] user_crc8, // Stored user preset
  input wire logic [4:0] user_crc5, // Stored user preset
  output logic driver_out_a, // First driver modulation level
  output logic driver_out_b, // Second driver modulation level
  output logic carrier_max, // Carrier at full amplitude
  output rtx_pkg::rtx_tx_cfg_type tx_cfg, // Transmitter settings
  output rtx_pkg::rtx_crc_cfg_type crc_cfg, // CRC generator settings
  input wire logic [15:0] crc_value, // Computed CRC from generator
  output logic [15:0] crc_send // CRC as it goes on the frame
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  rtx_pkg::rtx_state_type st_q; // Config registers and read data
  rtx_pkg::rtx_state_type st_d; // Next value
  logic [1:0] ser_sync_q; // Serial pin synchroniser
  logic mod_q; // Registered modulation level
  logic mod_d; // Next modulation level
  logic [1:0] drv_q; // Registered driver levels
  logic [1:0] drv_d; // Next driver levels
  logic [15:0] crc_send_q; // Registered outgoing CRC
  logic [15:0] crc_send_d; // Next outgoing CRC

  // Masked write helper, used for every register
  function automatic logic [7:0] mwrite(input logic [7:0] v,
                                        input logic [7:0] m);
    mwrite = v & m;
  endfunction : mwrite

  ////////////////////////////////////////////////////////////////////////////
  // Register write and read path
  always_comb begin
    st_d = st_q;
    st_d.rdata = 8'h00; // Read data valid one cycle only
    if (wr_stb) begin
      unique case (addr)
        rtx_pkg::ADDR_DRV_MODE: begin
          st_d.drv_mode = mwrite(wdata, rtx_pkg::MASK_DRV_MODE);
        end
        rtx_pkg::ADDR_AMP: begin
          st_d.amp = mwrite(wdata, rtx_pkg::MASK_AMP);
        end
        rtx_pkg::ADDR_TX_CTRL: begin
          st_d.tx_ctrl = mwrite(wdata, rtx_pkg::MASK_TX_CTRL);
        end
        rtx_pkg::ADDR_LOAD: begin
          st_d.load = mwrite(wdata, rtx_pkg::MASK_LOAD);
        end
        rtx_pkg::ADDR_CRC_CFG: begin
          st_d.crc_cfg = mwrite(wdata, rtx_pkg::MASK_CRC_CFG);
        end
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
    if (rd_stb) begin
      unique case (addr)
        rtx_pkg::ADDR_DRV_MODE: st_d.rdata = st_q.drv_mode;
        rtx_pkg::ADDR_AMP: st_d.rdata = st_q.amp;
        rtx_pkg::ADDR_TX_CTRL: st_d.rdata = st_q.tx_ctrl;
        rtx_pkg::ADDR_LOAD: st_d.rdata = st_q.load;
        rtx_pkg::ADDR_CRC_CFG: st_d.rdata = st_q.crc_cfg;
        default: st_d.rdata = 8'h00; // Unmapped reads give zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  always_comb begin
    tx_cfg.drivers_enable = st_q.drv_mode[rtx_pkg::DRV_EN_BIT];
    tx_cfg.output_stage_select = st_q.drv_mode[2:0];
    tx_cfg.carrier_reduction_sel = st_q.amp[7:6];
    tx_cfg.residual_carrier = st_q.amp[4:0];
    tx_cfg.overshoot_len_b = st_q.tx_ctrl[7:4];
    tx_cfg.overshoot_len_a = st_q.load[7:4];
    tx_cfg.load_current_trim = st_q.load[3:0];
    crc_cfg.crc_kind_sel = st_q.crc_cfg[3:2];
    crc_cfg.crc_output_invert = st_q.crc_cfg[rtx_pkg::CRC_INV_BIT];
    crc_cfg.crc_append_enable = st_q.crc_cfg[rtx_pkg::CRC_APPEND_BIT];
    crc_cfg.crc_start = crc_start(st_q.crc_cfg[6:4], st_q.crc_cfg[3:2]);
  end

  // Start value lookup; undefined codes fall back to zero
  function automatic logic [15:0] crc_start(input logic [2:0] code,
                                            input logic [1:0] kind);
    crc_start = 16'h0000;
    unique case (kind)
      rtx_pkg::CRC_KIND_16: begin
        unique case (code)
          3'h0: crc_start = rtx_pkg::CRC16_P0;
          3'h1: crc_start = rtx_pkg::CRC16_P1;
          3'h2: crc_start = rtx_pkg::CRC16_P2;
          3'h3: crc_start = rtx_pkg::CRC16_P3;
          rtx_pkg::PRESET_USER: crc_start = user_crc16;
          3'h7: crc_start = rtx_pkg::CRC16_P7;
          default: crc_start = 16'h0000;
        endcase
      end
      rtx_pkg::CRC_KIND_8: begin
        unique case (code)
          3'h0: crc_start = {8'h00, rtx_pkg::CRC8_P0};
          3'h1: crc_start = {8'h00, rtx_pkg::CRC8_P1};
          3'h2: crc_start = {8'h00, rtx_pkg::CRC8_P2};
          3'h3: crc_start = {8'h00, rtx_pkg::CRC8_P3};
          rtx_pkg::PRESET_USER: crc_start = {8'h00, user_crc8};
          3'h7: crc_start = {8'h00, rtx_pkg::CRC8_P7};
          default: crc_start = 16'h0000;
        endcase
      end
      rtx_pkg::CRC_KIND_5: begin
        unique case (code)
          3'h0: crc_start = {11'h000, rtx_pkg::CRC5_P0};
          3'h1: crc_start = {11'h000, rtx_pkg::CRC5_P1};
          rtx_pkg::PRESET_USER: crc_start = {11'h000, user_crc5};
          3'h7: crc_start = {11'h000, rtx_pkg::CRC5_P7};
          default: crc_start = 16'h0000;
        endcase
      end
      default: crc_start = 16'h0000; // Reserved kind
    endcase
  endfunction : crc_start

  ////////////////////////////////////////////////////////////////////////////
  // Modulation path: source select, invert, per-driver invert
  always_comb begin
    logic src;
    logic [15:0] kmask;
    src = 1'b0;
    kmask = 16'h0000;
    unique case (rtx_pkg::rtx_mod_src_type'(st_q.tx_ctrl[1:0]))
      rtx_pkg::MOD_NONE: src = 1'b0;
      rtx_pkg::MOD_ENVELOPE: src = internal_envelope;
      rtx_pkg::MOD_SERIAL: src = ser_sync_q[1];
      default: src = 1'b0; // Reserved code gives no modulation
    endcase
    mod_d = src ^ st_q.tx_ctrl[rtx_pkg::MOD_INV_BIT];
    // Disabled drivers rest low; fixed-level stages override
    if (!st_q.drv_mode[rtx_pkg::DRV_EN_BIT]) begin
      drv_d = 2'b00;
    end else begin
      unique case (rtx_pkg::rtx_stage_type'(st_q.drv_mode[2:0]))
        rtx_pkg::STAGE_FIX_LOW: drv_d = 2'b00;
        rtx_pkg::STAGE_FIX_HIGH: drv_d = 2'b11;
        rtx_pkg::STAGE_HIGH_Z: drv_d = 2'b00;
        default: begin
          drv_d[0] = mod_q ^ st_q.drv_mode[rtx_pkg::DRV_INV_A_BIT];
          drv_d[1] = mod_q ^ st_q.drv_mode[rtx_pkg::DRV_INV_B_BIT];
        end
      endcase
    end
    // CRC width mask for inversion
    unique case (st_q.crc_cfg[3:2])
      rtx_pkg::CRC_KIND_16: kmask = 16'hffff;
      rtx_pkg::CRC_KIND_8: kmask = 16'h00ff;
      rtx_pkg::CRC_KIND_5: kmask = 16'h001f;
      default: kmask = 16'h0000;
    endcase
    if (!st_q.crc_cfg[rtx_pkg::CRC_APPEND_BIT]) begin
      crc_send_d = 16'h0000;
    end else if (st_q.crc_cfg[rtx_pkg::CRC_INV_BIT]) begin
      crc_send_d = (~crc_value) & kmask;
    end else begin
      crc_send_d = crc_value & kmask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; clock enable freezes everything
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '{drv_mode: rtx_pkg::RST_REG, amp: rtx_pkg::RST_REG,
                tx_ctrl: rtx_pkg::RST_REG, load: rtx_pkg::RST_REG,
                crc_cfg: rtx_pkg::RST_REG, rdata: rtx_pkg::RST_REG};
      ser_sync_q <= 2'b00;
      mod_q <= 1'b0;
      drv_q <= 2'b00;
      crc_send_q <= 16'h0000;
    end else if (clk_en) begin
      st_q <= st_d;
      ser_sync_q <= {ser_sync_q[0], external_serial_input};
      mod_q <= mod_d;
      drv_q <= drv_d;
      crc_send_q <= crc_send_d;
    end
  end

  // Outputs
  assign rdata = st_q.rdata;
  assign driver_out_a = drv_q[0];
  assign driver_out_b = drv_q[1];
  assign carrier_max = st_q.tx_ctrl[rtx_pkg::CWMAX_BIT];
  assign crc_send = crc_send_q;

endmodule : rtx_cfg_bank
`default_nettype wire

// >>> hw/rtx_pkg.sv
// Function
// - Bit 7 inverts second driver output
// - Bit 6 inverts first driver output
// - Bit 3 enables both driver outputs
// - Output stage mode field; unsupported codes avoided
// - Two-bit carrier amplitude reduction select
// - Five-bit residual carrier percentage field
// - Overshoot length B in carrier cycles
// - Carrier maximum overrides amplitude reduction
// - Invert modulation after source select
// - Modulation source: none, envelope, serial
// - Overshoot length A for first timer
// - Load current factory trim field
// - CRC preset code selects start value
// - CRC kind: five, eight, sixteen bit
// - Preset code six uses user value
// - Invert computed CRC before appending
// - Append CRC when enabled
package rtx_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_DRV_MODE = 8'h28;
  localparam logic [7:0] ADDR_AMP = 8'h29;
  localparam logic [7:0] ADDR_TX_CTRL = 8'h2a;
  localparam logic [7:0] ADDR_LOAD = 8'h2b;
  localparam logic [7:0] ADDR_CRC_CFG = 8'h2c;

  // Writable bit masks; reserved bits are zero
  localparam logic [7:0] MASK_DRV_MODE = 8'hcf;
  localparam logic [7:0] MASK_AMP = 8'hdf;
  localparam logic [7:0] MASK_TX_CTRL = 8'hff;
  localparam logic [7:0] MASK_LOAD = 8'hff;
  localparam logic [7:0] MASK_CRC_CFG = 8'h7f;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // Field positions
  localparam int DRV_INV_B_BIT = 7;
  localparam int DRV_INV_A_BIT = 6;
  localparam int DRV_EN_BIT = 3;
  localparam int CWMAX_BIT = 3;
  localparam int MOD_INV_BIT = 2;
  localparam int CRC_INV_BIT = 1;
  localparam int CRC_APPEND_BIT = 0;

  // Output stage codes (011 and 110 unsupported)
  typedef enum logic [2:0] {
    STAGE_OPEN_DRAIN = 3'h0,
    STAGE_PUSH_PULL = 3'h1,
    STAGE_HIGH_Z = 3'h2,
    STAGE_BAD_A = 3'h3,
    STAGE_FIX_LOW = 3'h4,
    STAGE_FIX_HIGH = 3'h5,
    STAGE_BAD_B = 3'h6,
    STAGE_PUSH_PULL_B = 3'h7
  } rtx_stage_type;

  // Modulation sources
  typedef enum logic [1:0] {
    MOD_NONE = 2'h0,
    MOD_ENVELOPE = 2'h1,
    MOD_SERIAL = 2'h2,
    MOD_RESERVED = 2'h3
  } rtx_mod_src_type;

  // CRC kinds
  typedef enum logic [1:0] {
    CRC_KIND_5 = 2'h0,
    CRC_KIND_8 = 2'h1,
    CRC_KIND_16 = 2'h2,
    CRC_KIND_RES = 2'h3
  } rtx_crc_kind_type;

  // Preset codes of interest
  localparam logic [2:0] PRESET_USER = 3'h6;

  // Preset constants, by code 0..3 and 7; CRC5 has codes 0, 1 and 7 only
  localparam logic [15:0] CRC16_P0 = 16'h0000;
  localparam logic [15:0] CRC16_P1 = 16'h6363;
  localparam logic [15:0] CRC16_P2 = 16'ha671;
  localparam logic [15:0] CRC16_P3 = 16'hfffe;
  localparam logic [15:0] CRC16_P7 = 16'hffff;
  localparam logic [7:0] CRC8_P0 = 8'h00;
  localparam logic [7:0] CRC8_P1 = 8'h12;
  localparam logic [7:0] CRC8_P2 = 8'hbf;
  localparam logic [7:0] CRC8_P3 = 8'hfd;
  localparam logic [7:0] CRC8_P7 = 8'hff;
  localparam logic [4:0] CRC5_P0 = 5'h00;
  localparam logic [4:0] CRC5_P1 = 5'h12;
  localparam logic [4:0] CRC5_P7 = 5'h1f;

  // Register state
  typedef struct packed {
    logic [7:0] drv_mode;
    logic [7:0] amp;
    logic [7:0] tx_ctrl;
    logic [7:0] load;
    logic [7:0] crc_cfg;
    logic [7:0] rdata;
  } rtx_state_type;

  // Decoded transmitter settings
  typedef struct packed {
    logic drivers_enable;
    logic [2:0] output_stage_select;
    logic [1:0] carrier_reduction_sel;
    logic [4:0] residual_carrier;
    logic [3:0] overshoot_len_a;
    logic [3:0] overshoot_len_b;
    logic [3:0] load_current_trim;
  } rtx_tx_cfg_type;

  // Decoded CRC settings
  typedef struct packed {
    logic [1:0] crc_kind_sel;
    logic [15:0] crc_start;
    logic crc_output_invert;
    logic crc_append_enable;
  } rtx_crc_cfg_type;

endpackage : rtx_pkg

// >>> dv/rtx_cfg_bank_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rtx_cfg_bank_properties (
  input wire logic clk, // System clock
  input wire logic reset, // Sync reset
  input wire logic clk_en, // Advance enable
  input wire logic [7:0] addr, // Address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr_stb, // Write strobe
  input wire logic rd_stb, // Read strobe
  input wire logic [7:0] rdata, // Read data
  input wire logic driver_out_a, // First driver
  input wire logic driver_out_b, // Second driver
  input wire logic carrier_max, // Full carrier
  input wire rtx_pkg::rtx_tx_cfg_type tx_cfg, // Tx settings
  input wire rtx_pkg::rtx_crc_cfg_type crc_cfg, // CRC settings
  input wire logic [15:0] crc_send // CRC on frame
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Taken writes; a frozen clock enable must not count
  logic wr_amp, wr_ctl, wr_ld, wr_crc;
  assign wr_amp = clk_en && wr_stb && addr == 8'h29;
  assign wr_ctl = clk_en && wr_stb && addr == 8'h2a;
  assign wr_ld = clk_en && wr_stb && addr == 8'h2b;
  assign wr_crc = clk_en && wr_stb && addr == 8'h2c;
  ////////////////////////////////////////////////////////////////////
  drv_off_a: assert property (
    clk_en && !tx_cfg.drivers_enable |=> !driver_out_a && !driver_out_b)
    else $error("drivers active while disabled");
  fix_low_a: assert property (
    clk_en && tx_cfg.drivers_enable && tx_cfg.output_stage_select == 3'h4
    |=> !driver_out_a && !driver_out_b) else $error("fixed low broken");
  fix_high_a: assert property (
    clk_en && tx_cfg.drivers_enable && tx_cfg.output_stage_select == 3'h5
    |=> driver_out_a && driver_out_b) else $error("fixed high broken");
  cw_max_a: assert property (
    wr_ctl |=> carrier_max == $past(wdata[3])) else $error("carrier max");
  amp_fields_a: assert property (
    wr_amp |=> tx_cfg.carrier_reduction_sel == $past(wdata[7:6])
    && tx_cfg.residual_carrier == $past(wdata[4:0])) else $error("amp");
  ovs_b_a: assert property (
    wr_ctl |=> tx_cfg.overshoot_len_b == $past(wdata[7:4]))
    else $error("overshoot b");
  load_fields_a: assert property (
    wr_ld |=> tx_cfg.overshoot_len_a == $past(wdata[7:4])
    && tx_cfg.load_current_trim == $past(wdata[3:0])) else $error("load");
  crc_bits_a: assert property (
    wr_crc |=> crc_cfg.crc_kind_sel == $past(wdata[3:2])
    && crc_cfg.crc_output_invert == $past(wdata[1])
    && crc_cfg.crc_append_enable == $past(wdata[0])) else $error("crc");
  crc_off_a: assert property (
    clk_en && !crc_cfg.crc_append_enable |=> crc_send == 16'h0000)
    else $error("crc sent while append off");
  rsv_read_a: assert property (
    clk_en && rd_stb && addr == 8'h28 |=> rdata[5:4] == 2'h0)
    else $error("reserved bits read nonzero");
  // Main scenarios reached
  cover property (wr_crc);
  cover property (tx_cfg.output_stage_select == 3'h5 && driver_out_a);
  cover property (rd_stb && addr == 8'h2c);
endmodule : rtx_cfg_bank_properties
bind rtx_cfg_bank rtx_cfg_bank_properties u_props (.clk, .reset,
  .clk_en, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .driver_out_a,
  .driver_out_b, .carrier_max, .tx_cfg, .crc_cfg, .crc_send);
`default_nettype wire

// >>> dv/rtx_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtx_far_model #(
  parameter logic [15:0] CRC_VAL = 16'h1234, // Generator result
  parameter logic [15:0] USER16 = 16'h5a5a, // Stored user presets
  parameter logic [7:0] USER8 = 8'h3c, // Stored user presets
  parameter logic [4:0] USER5 = 5'h0b // Stored user presets
) (
  input wire logic clk, // System clock
  input wire logic env_req, // Wanted envelope level
  input wire logic ser_req, // Wanted pin level
  output logic internal_envelope = 1'b0, // Envelope, same clock
  output logic external_serial_input = 1'b0, // Async pin
  output logic [15:0] crc_value, // Generator output
  output logic [15:0] user_crc16, // Memory preset
  output logic [7:0] user_crc8, // Memory preset
  output logic [4:0] user_crc5 // Memory preset
);
  // Envelope is clocked; pin moves off-edge like a real async source
  always @(posedge clk) internal_envelope <= env_req;
  always @(negedge clk) external_serial_input <= ser_req;
  assign crc_value = CRC_VAL;
  assign user_crc16 = USER16;
  assign user_crc8 = USER8;
  assign user_crc5 = USER5;
endmodule : rtx_far_model
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, reset, clk_en, wr_stb, rd_stb, env_req, ser_req;
  logic [7:0] addr, wdata, rdata, u8;
  logic drv_a, drv_b, cmax, env, ser;
  logic [15:0] cval, u16, csend;
  logic [4:0] u5;
  rtx_pkg::rtx_tx_cfg_type tx_cfg;
  rtx_pkg::rtx_crc_cfg_type crc_cfg;
  int n_fail = 0, total_checks = 0, cyc = 0;
  // Register table: masks show reserved bits as zero
  logic [7:0] msk [0:4] = '{8'hcf, 8'hdf, 8'hff, 8'hff, 8'h7f};
  // Drive table; stage codes 3 and 6 never programmed
  logic [7:0] mctl [0:11] = '{1, 1, 1, 5, 2, 2, 0, 1, 0, 1, 3, 1};
  logic [7:0] mmod [0:11] = '{9, 'h89, 'h49, 9, 9, 9, 9, 'hc, 'hd, 1, 9, 8};
  logic [1:0] msrc [0:11] = '{2, 2, 2, 2, 1, 2, 3, 2, 0, 2, 3, 2};
  logic [1:0] mexp [0:11] = '{3, 2, 1, 0, 3, 0, 0, 0, 3, 0, 0, 3};
  // CRC table: config byte, then start value and sent value
  logic [7:0] ccfg [0:11] = '{'h19, 'h2b, 'h39, 'h79, 'h69, 'h09,
    'h14, 'h25, 'h65, 'h71, 'h63, 'h37};
  logic [31:0] cexp [0:11] = '{'h6363_1234, 'ha671_edcb, 'hfffe_1234,
    'hffff_1234, 'h5a5a_1234, 'h0000_1234, 'h0012_0000, 'h00bf_0034,
    'h003c_0034, 'h001f_0014, 'h000b_000b, 'h00fd_00cb};
  rtx_cfg_bank DUT (.clk(clk), .reset(reset), .clk_en(clk_en),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .internal_envelope(env), .external_serial_input(ser),
    .user_crc16(u16), .user_crc8(u8), .user_crc5(u5),
    .driver_out_a(drv_a), .driver_out_b(drv_b), .carrier_max(cmax),
    .tx_cfg(tx_cfg), .crc_cfg(crc_cfg), .crc_value(cval),
    .crc_send(csend));
  rtx_far_model u_far (.clk(clk), .env_req(env_req), .ser_req(ser_req),
    .internal_envelope(env), .external_serial_input(ser),
    .crc_value(cval), .user_crc16(u16), .user_crc8(u8), .user_crc5(u5));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk({24'h0, rdata}, {24'h0, e});
  endtask : rd
  task end_sim;
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard, far above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    {reset, clk_en} = 2'b11;
    {wr_stb, rd_stb, env_req, ser_req, addr, wdata} = '0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // Strobes ignored while frozen
    clk_en <= 1'b0;
    wr(8'h29, 8'hff);
    clk_en <= 1'b1;
    rd(8'h29, 8'h00);
    for (int i = 0; i < 5; i++) begin
      rd(8'h28 + i[7:0], 8'h00);
      wr(8'h28 + i[7:0], 8'hff);
      rd(8'h28 + i[7:0], msk[i]);
    end
    wr(8'h2d, 8'hff);
    rd(8'h2d, 8'h00);
    chk({9'h0, tx_cfg}, 32'h007f_ffff);
    chk({31'h0, cmax}, 32'h1);
    for (int i = 0; i < 12; i++) begin
      env_req <= msrc[i][1];
      ser_req <= msrc[i][0];
      wr(8'h2a, mctl[i]);
      wr(8'h28, mmod[i]);
      repeat (6) @(posedge clk);
      #1;
      chk({30'h0, drv_a, drv_b}, {30'h0, mexp[i]});
    end
    // High impedance stage rests low; code 7 passes modulation
    wr(8'h28, 8'h0a);
    repeat (3) @(posedge clk);
    #1;
    chk({30'h0, drv_a, drv_b}, 32'h0);
    wr(8'h28, 8'h0f);
    repeat (3) @(posedge clk);
    #1;
    chk({30'h0, drv_a, drv_b}, 32'h3);
    for (int i = 0; i < 12; i++) begin
      wr(8'h2c, ccfg[i]);
      repeat (3) @(posedge clk);
      #1;
      chk({crc_cfg.crc_start, csend}, cexp[i]);
    end
    end_sim();
  end
endmodule : testbench
`default_nettype wire
